// ### rtl/gbicp_parser.sv
/*
 Binary input command parser. Receives framed bytes, checks framing,
 length and checksum, then applies initialize, protocol-switch and
 almanac fields. Assumes rx bytes come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module gbicp_parser (
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               clk_en,
   input  wire logic [7:0]         rx_data,
   input  wire logic               rx_valid,
   output logic                    rx_ready,
   input  wire logic [8:0]         alm_rd_index,
   output logic [15:0]             alm_rd_data,
   output gbicp_pkg::gbicp_init_s  init_cfg,
   output logic                    init_stb,
   output logic [31:0]             lib_msg_mask,
   output logic [15:0]             baud_out,
   output gbicp_pkg::gbicp_nmea_s  nmea_cfg,
   output logic                    nmea_stb,
   output logic                    alm_stb,
   output logic                    frame_err
);
   typedef enum {
      S_SYNC0, S_SYNC1, S_LENH, S_LENL, S_PAY, S_CKH, S_CKL, S_END0, S_END1
   } gbicp_state_e;

   // Two-entry skid buffer feeds the parser, which pops a byte on every enabled cycle that the buffer is not empty and never stalls.
   logic [7:0] buf_q [2];
   logic [7:0] buf_d [2];
   logic [1:0] cnt_q, cnt_d;
   logic       pop;
   logic [7:0] byte_in;
   assign byte_in = buf_q[0];
   always_comb begin
      buf_d = buf_q;
      cnt_d = cnt_q;
      if (pop) begin
         buf_d[0] = buf_q[1];
         cnt_d = cnt_d - 2'h1;
      end
      if (rx_valid && rx_ready) begin
         buf_d[(pop ? cnt_q - 2'h1 : cnt_q) == 2'h0 ? 0 : 1] = rx_data;
         cnt_d = cnt_d + 2'h1;
      end
   end

   // Framing state and payload capture.
   gbicp_state_e st_q, st_d;
   logic [14:0]  len_q, len_d, idx_q, idx_d, sum_q, sum_d;
   logic [7:0]   ckh_q, ckh_d, id_q, id_d;
   logic [7:0]   pl_q [25];
   logic [7:0]   pl_d [25];
   logic [7:0]   alm_hi_q, alm_hi_d;
   logic         alm_we;
   logic [15:0]  alm_mem [gbicp_pkg::ALM_WORDS];
   logic [15:0]  stage_mem [gbicp_pkg::ALM_WORDS];
   logic         fin, ok, len_ok;
   assign pop = (cnt_q != 2'h0);

   function automatic logic [14:0] fixed_len(input logic [7:0] id);
      case (id)
         gbicp_pkg::ID_INIT: fixed_len = gbicp_pkg::LEN_INIT;
         gbicp_pkg::ID_NMEA: fixed_len = gbicp_pkg::LEN_NMEA;
         gbicp_pkg::ID_ALM:  fixed_len = gbicp_pkg::LEN_ALM;
         default:            fixed_len = 15'h0000;
      endcase
   endfunction : fixed_len

   function automatic logic [31:0] be32(input logic [7:0] a, b, c, d);
      be32 = {a, b, c, d};
   endfunction : be32

   assign len_ok = (fixed_len(id_q) == len_q);
   always_comb begin
      st_d = st_q;
      len_d = len_q;
      idx_d = idx_q;
      sum_d = sum_q;
      ckh_d = ckh_q;
      id_d = id_q;
      pl_d = pl_q;
      alm_hi_d = alm_hi_q;
      alm_we = 1'b0;
      fin = 1'b0;
      ok = 1'b0;
      if (pop) begin
         case (st_q)
            S_SYNC0: if (byte_in == gbicp_pkg::START0) st_d = S_SYNC1;
            S_SYNC1: st_d = (byte_in == gbicp_pkg::START1) ? S_LENH : S_SYNC0;
            S_LENH: begin
               len_d = {byte_in[6:0], 8'h00};
               st_d = (byte_in < gbicp_pkg::LEN_HI_LIMIT) ? S_LENL
                                                          : S_SYNC0;
            end
            S_LENL: begin
               len_d = {len_q[14:8], byte_in};
               idx_d = 15'h0000;
               sum_d = 15'h0000;
               st_d = ({len_q[14:8], byte_in} == 15'h0000) ? S_SYNC0 : S_PAY;
            end
            S_PAY: begin
               sum_d = sum_q + {7'h00, byte_in};
               if (idx_q == 15'h0000) id_d = byte_in;
               if (idx_q < 15'd25) pl_d[idx_q[4:0]] = byte_in;
               // Almanac words pair high byte first after the identifier.
               if (idx_q[0] == 1'b1) alm_hi_d = byte_in;
               else if (idx_q != 15'h0000) alm_we = (id_q == gbicp_pkg::ID_ALM);
               idx_d = idx_q + 15'h0001;
               if (idx_q + 15'h0001 == len_q) st_d = S_CKH;
            end
            S_CKH: begin
               ckh_d = byte_in;
               st_d = S_CKL;
            end
            S_CKL: st_d = ({ckh_q[6:0], byte_in} == sum_q) ? S_END0 : S_SYNC0;
            S_END0: st_d = (byte_in == gbicp_pkg::END0) ? S_END1 : S_SYNC0;
            S_END1: begin
               st_d = S_SYNC0;
               fin = 1'b1;
               ok = (byte_in == gbicp_pkg::END1) && len_ok;
            end
            default: st_d = S_SYNC0;
         endcase
      end
   end

   // Decoded outputs, applied only when a whole frame checks out.
   gbicp_pkg::gbicp_init_s init_d;
   gbicp_pkg::gbicp_nmea_s nmea_d;
   logic [31:0] mask_d;
   logic [15:0] baud_d, nbaud;
   always_comb begin
      init_d = init_cfg;
      nmea_d = nmea_cfg;
      mask_d = lib_msg_mask;
      baud_d = baud_out;
      nbaud = {pl_q[gbicp_pkg::OFS_BAUD],
               pl_q[gbicp_pkg::OFS_BAUD + 1]};
      if (ok && id_q == gbicp_pkg::ID_INIT) begin
         init_d.earth_fixed_x_coordinate =
            be32(pl_q[1], pl_q[2], pl_q[3], pl_q[4]);
         init_d.earth_fixed_y_coordinate =
            be32(pl_q[5], pl_q[6], pl_q[7], pl_q[8]);
         init_d.earth_fixed_z_coordinate =
            be32(pl_q[9], pl_q[10], pl_q[11], pl_q[12]);
         init_d.clock_offset = be32(pl_q[13], pl_q[14], pl_q[15], pl_q[16]);
         // Divider is combinational; fine at 10 MHz, costly in area.
         init_d.tow_seconds = be32(pl_q[17], pl_q[18], pl_q[19], pl_q[20])
                              / gbicp_pkg::TOW_SCALE;
         init_d.week = {pl_q[21], pl_q[22]};
         init_d.channels = (pl_q[gbicp_pkg::OFS_CHAN] > gbicp_pkg::CHAN_MAX)
                         ? gbicp_pkg::CHAN_MAX
                         : ((pl_q[gbicp_pkg::OFS_CHAN] == 8'h00) ? 8'h01
                         : pl_q[gbicp_pkg::OFS_CHAN]);
         init_d.data_valid      = pl_q[gbicp_pkg::OFS_OPT][0];
         init_d.clear_ephemeris = pl_q[gbicp_pkg::OFS_OPT][1];
         init_d.clear_memory    = pl_q[gbicp_pkg::OFS_OPT][2];
         init_d.factory_reset   = pl_q[gbicp_pkg::OFS_OPT][3];
         init_d.raw_track_en    = pl_q[gbicp_pkg::OFS_OPT][4];
         init_d.bin_debug_en    = pl_q[gbicp_pkg::OFS_OPT][5];
         init_d.txt_debug_en    = pl_q[gbicp_pkg::OFS_OPT][6];
         if (pl_q[gbicp_pkg::OFS_OPT][5]) begin
            // Bits 7, 8, 17 and 28 to 31 name the added output messages.
            mask_d = 32'hf0020180;
            baud_d = gbicp_pkg::BAUD_LIB;
         end else begin
            mask_d = 32'h00000000;
         end
      end
      if (ok && id_q == gbicp_pkg::ID_NMEA) begin
         nmea_d.mode = pl_q[gbicp_pkg::OFS_MODE];
         for (int i = 0; i < 6; i++) begin
            nmea_d.rate[i*8 +: 8] = pl_q[2 + 2*i];
            nmea_d.cks_en[i] = (pl_q[3 + 2*i] == 8'h01);
         end
         nmea_d.baud = nbaud;
         nmea_d.baud_ok = (nbaud == gbicp_pkg::BAUD_38400) ||
                          (nbaud == gbicp_pkg::BAUD_19200) ||
                          (nbaud == gbicp_pkg::BAUD_9600) ||
                          (nbaud == gbicp_pkg::BAUD_4800) ||
                          (nbaud == gbicp_pkg::BAUD_2400);
         if (nmea_d.baud_ok) baud_d = nbaud;
      end
   end

   // Almanac bytes land in a staging array and commit on a good frame.
   logic [8:0] widx;
   assign widx = 9'((idx_q - 15'h0002) >> 1);
   always_ff @(posedge core_clk) begin
      if (clk_en && alm_we) stage_mem[widx] <= {alm_hi_q, byte_in};
      if (clk_en) alm_rd_data <= alm_mem[alm_rd_index];
   end
   always_ff @(posedge core_clk) begin
      if (clk_en && ok && id_q == gbicp_pkg::ID_ALM) alm_mem <= stage_mem;
   end

   // State registers.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= S_SYNC0;
         cnt_q <= 2'h0;
         buf_q <= '{default: 8'h00};
         len_q <= 15'h0000;
         idx_q <= 15'h0000;
         sum_q <= 15'h0000;
         ckh_q <= 8'h00;
         id_q <= 8'h00;
         pl_q <= '{default: 8'h00};
         alm_hi_q <= 8'h00;
         rx_ready <= 1'b0;
         init_cfg <= '0;
         nmea_cfg <= '0;
         lib_msg_mask <= 32'h00000000;
         baud_out <= gbicp_pkg::BAUD_4800;
         init_stb <= 1'b0;
         nmea_stb <= 1'b0;
         alm_stb <= 1'b0;
         frame_err <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         buf_q <= buf_d;
         len_q <= len_d;
         idx_q <= idx_d;
         sum_q <= sum_d;
         ckh_q <= ckh_d;
         id_q <= id_d;
         pl_q <= pl_d;
         alm_hi_q <= alm_hi_d;
         rx_ready <= (cnt_d != 2'h2);
         init_cfg <= init_d;
         nmea_cfg <= nmea_d;
         lib_msg_mask <= mask_d;
         baud_out <= baud_d;
         init_stb <= ok && (id_q == gbicp_pkg::ID_INIT);
         nmea_stb <= ok && (id_q == gbicp_pkg::ID_NMEA);
         alm_stb <= ok && (id_q == gbicp_pkg::ID_ALM);
         frame_err <= fin && !ok;
      end
   end

   a_lib_mask: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      init_stb && init_cfg.bin_debug_en |-> lib_msg_mask == 32'hf0020180)
      else $error("library message mask wrong");
   a_lib_baud: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      init_stb && init_cfg.bin_debug_en |-> baud_out == 16'he100)
      else $error("library baud not 57600");
   a_chan_range: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      init_stb |-> init_cfg.channels inside {[8'h01:8'h0c]})
      else $error("channel count out of range");
   a_len_gate: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && fin && !len_ok |=> !init_stb && !nmea_stb && !alm_stb)
      else $error("bad length applied");
   a_one_stb: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $onehot0({init_stb, nmea_stb, alm_stb}))
      else $error("two strobes at once");
   // The sum is compared at 15 bits, so a carry out of bit 14 must vanish.
   a_sum_wrap: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && pop && st_q == S_PAY
      |=> sum_q == $past(sum_q) + 15'($past(byte_in)))
      else $error("payload sum not kept to 15 bits");
   a_nmea_baud: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      nmea_stb && nmea_cfg.baud_ok |-> baud_out == nmea_cfg.baud)
      else $error("baud not applied");
   a_cks_flag: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && ok && id_q == gbicp_pkg::ID_NMEA
      |=> nmea_cfg.cks_en[0] == ($past(pl_q[3]) == 8'h01))
      else $error("checksum flag wrong");
endmodule : gbicp_parser
`default_nettype wire

// ### rtl/gbicp_pkg.sv
/*
 Package for the binary input command parser: framing bytes, message
 identifiers, payload lengths, field layouts and decoded-output structs.
 Assumes a byte-wide receive stream from a UART on the same clock.
*/
package gbicp_pkg;
   localparam logic [7:0]  START0 = 8'ha0;
   localparam logic [7:0]  START1 = 8'ha2;
   localparam logic [7:0]  END0   = 8'hb0;
   localparam logic [7:0]  END1   = 8'hb3;
   localparam logic [7:0]  ID_INIT = 8'h80;
   localparam logic [7:0]  ID_NMEA = 8'h81;
   localparam logic [7:0]  ID_ALM  = 8'h82;
   localparam logic [14:0] LEN_INIT = 15'h0019;
   localparam logic [14:0] LEN_NMEA = 15'h0018;
   localparam logic [14:0] LEN_ALM  = 15'h0381;
   localparam logic [7:0]  LEN_HI_LIMIT = 8'h7f;
   localparam logic [31:0] TOW_SCALE = 32'h00000064;
   localparam logic [7:0]  CHAN_MAX = 8'h0c;
   localparam logic [15:0] BAUD_LIB = 16'he100;
   localparam logic [15:0] BAUD_38400 = 16'h9600;
   localparam logic [15:0] BAUD_19200 = 16'h4b00;
   localparam logic [15:0] BAUD_9600  = 16'h2580;
   localparam logic [15:0] BAUD_4800  = 16'h12c0;
   localparam logic [15:0] BAUD_2400  = 16'h0960;
   localparam int ALM_WORDS = 448;
   localparam int ALM_PER_SV = 14;
   // Payload byte offsets (identifier at 0).
   localparam int OFS_OPT   = 24;
   localparam int OFS_CHAN  = 23;
   localparam int OFS_MODE  = 1;
   localparam int OFS_BAUD  = 22;
   typedef struct packed {
      logic [31:0] earth_fixed_x_coordinate;
      logic [31:0] earth_fixed_y_coordinate;
      logic [31:0] earth_fixed_z_coordinate;
      logic [31:0] clock_offset;
      logic [31:0] tow_seconds;
      logic [15:0] week;
      logic [7:0]  channels;
      logic        data_valid;
      logic        clear_ephemeris;
      logic        clear_memory;
      logic        factory_reset;
      logic        raw_track_en;
      logic        bin_debug_en;
      logic        txt_debug_en;
   } gbicp_init_s;
   typedef struct packed {
      logic [7:0]  mode;
      logic [47:0] rate;
      logic [5:0]  cks_en;
      logic [15:0] baud;
      logic        baud_ok;
   } gbicp_nmea_s;
   typedef struct packed {
      logic [8:0]  index;
      logic [15:0] value;
   } gbicp_alm_s;
endpackage : gbicp_pkg

// ### testbench/gbicp_host_model.sv
/*
 Host model that frames binary commands for the parser.
 Assumes the bench calls send_frame just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module gbicp_host_model (
   input  wire logic       core_clk,
   input  wire logic       clk_en,
   input  wire logic       rx_ready,
   output logic [7:0]      rx_data,
   output logic            rx_valid
);
   int   gap  = 0;    // Idle cycles between bytes, set by the bench.
   logic hung = 1'b0; // Set when a byte is never taken.
   initial begin
      rx_data  = 8'h5a;
      rx_valid = 1'b0;
   end
   // Holds each byte until it is taken at a rising edge.
   task automatic send_byte(input logic [7:0] b);
      int n;
      n = 0;
      if (gap > 0) begin
         // The gap comes before the byte, so a frame's last byte is
         // followed at once by the bench's strobe window.
         // Idle data shows the inverse, so an early take never matches.
         rx_valid <= 1'b0;
         rx_data  <= ~b;
         repeat (gap) @(posedge core_clk);
      end
      rx_valid <= 1'b1;
      rx_data  <= b;
      do begin
         @(posedge core_clk);
         n++;
      end while (!(rx_ready && clk_en) && n < 2000);
      if (n >= 2000) hung = 1'b1;
   endtask : send_byte
   // Fault 1 spoils the checksum, fault 2 the last end byte.
   task automatic send_frame(input logic [7:0] pl [$], input int fault);
      logic [14:0] ck;
      ck = 15'h0000;
      foreach (pl[i]) ck = ck + 15'(pl[i]);
      if (fault == 1) ck = ck + 15'h0001;
      send_byte(gbicp_pkg::START0);
      send_byte(gbicp_pkg::START1);
      send_byte(8'(pl.size() >> 8));
      send_byte(8'(pl.size()));
      foreach (pl[i]) send_byte(pl[i]);
      send_byte({1'b0, ck[14:8]});
      send_byte(ck[7:0]);
      send_byte(gbicp_pkg::END0);
      send_byte(fault == 2 ? 8'hb4 : gbicp_pkg::END1);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
   endtask : send_frame
endmodule : gbicp_host_model
`default_nettype wire

// ### testbench/gbicp_parser_tb_top.sv
/*
 Self-checking bench for the command parser with a framing host model.
 Assumes one 10 MHz clock and random clock-enable gaps.
*/
`timescale 1ns/1ps
`default_nettype none
module gbicp_parser_tb_top;
   logic                   core_clk = 1'b0;
   logic                   sys_rst  = 1'b1;
   logic                   clk_en   = 1'b1;
   logic                   jit      = 1'b0;
   logic [7:0]             rx_data;
   logic                   rx_valid, rx_ready, init_stb, nmea_stb;
   logic                   alm_stb, frame_err;
   logic [8:0]             alm_rd_index = 9'h000;
   logic [15:0]            alm_rd_data, baud_out, e_baud;
   logic [31:0]            lib_msg_mask, w, seed = 32'h7, e_mask = 32'h0;
   gbicp_pkg::gbicp_init_s init_cfg, e_init;
   gbicp_pkg::gbicp_nmea_s nmea_cfg, e_nmea;
   logic [15:0]            alm_e [448];
   logic [7:0]             pl [$];
   int                     errors = 0, n_checks = 0, ci, cn, ca, ce;
   gbicp_parser dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .alm_rd_index(alm_rd_index),
      .alm_rd_data(alm_rd_data), .init_cfg(init_cfg), .init_stb(init_stb),
      .lib_msg_mask(lib_msg_mask), .baud_out(baud_out),
      .nmea_cfg(nmea_cfg), .nmea_stb(nmea_stb), .alm_stb(alm_stb),
      .frame_err(frame_err));
   gbicp_host_model host (.core_clk(core_clk), .clk_en(clk_en),
      .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
   always #50 core_clk = ~core_clk;
   // Random enable gaps stretch every transfer after the first initialize frame; off during reads.
   always @(posedge core_clk) clk_en <= !jit || (rnd() % 5 != 0);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] exp_chan(input logic [7:0] c);
      return (c == 8'h00) ? 8'h01 : (c > 8'h0c) ? 8'h0c : c;
   endfunction : exp_chan
   task automatic chk(input string nm, input logic [191:0] e, g);
      n_checks++;
      if (e !== g) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic put32(input logic [31:0] v);
      for (int i = 3; i >= 0; i--) pl.push_back(v[i*8+:8]);
   endtask : put32
   // Sends the frame, then counts each strobe over a fixed window.
   task automatic run(input int f, xi, xn, xa, xe);
      ci = 0; cn = 0; ca = 0; ce = 0;
      host.send_frame(pl, f);
      repeat (40) begin
         @(posedge core_clk);
         #1;
         // A pulse stands until the next enabled edge; count it once there.
         ci += int'(init_stb === 1'b1 && clk_en === 1'b1);
         cn += int'(nmea_stb === 1'b1 && clk_en === 1'b1);
         ca += int'(alm_stb === 1'b1 && clk_en === 1'b1);
         ce += int'(frame_err === 1'b1 && clk_en === 1'b1);
      end
      chk("init strobes", 192'(xi), 192'(ci));
      chk("nmea strobes", 192'(xn), 192'(cn));
      chk("alm strobes", 192'(xa), 192'(ca));
      chk("frame errors", 192'(xe), 192'(ce));
      chk("host hung", 192'(0), 192'(host.hung));
   endtask : run
   // Bad: 1 checksum, 2 end byte, 3 one byte short.
   task automatic do_init(input logic [31:0] x, y, z, co, tow,
                          input logic [15:0] wk, input logic [7:0] ch, o,
                          input int bad);
      gbicp_pkg::gbicp_init_s t;
      t = '{x, y, z, co, tow / 32'd100, wk, exp_chan(ch), o[0], o[1], o[2],
            o[3], o[4], o[5], o[6]};
      pl = {gbicp_pkg::ID_INIT};
      put32(x); put32(y); put32(z); put32(co); put32(tow);
      pl.push_back(wk[15:8]);
      pl.push_back(wk[7:0]);
      pl.push_back(ch);
      pl.push_back(o);
      if (bad == 3) void'(pl.pop_back());
      if (bad == 0) e_init = t;
      if (bad == 0 && o[5]) e_baud = gbicp_pkg::BAUD_LIB;
      // Added messages 7, 8, 17 and 28 to 31 map to their own mask bits.
      if (bad == 0) e_mask = o[5] ? 32'hf0020180 : 32'h00000000;
      run(bad % 3, int'(bad == 0), 0, 0, int'(bad >= 2));
      chk("init cfg", 192'(e_init), 192'(init_cfg));
      chk("baud", 192'(e_baud), 192'(baud_out));
      chk("lib mask", 192'(e_mask), 192'(lib_msg_mask));
   endtask : do_init
   task automatic do_nmea(input logic [15:0] bd, input int bad);
      gbicp_pkg::gbicp_nmea_s t;
      w = rnd();
      t.mode = w[7:0];
      pl = {gbicp_pkg::ID_NMEA, t.mode};
      for (int i = 0; i < 6; i++) begin
         w = rnd();
         if (i < 2) w[7:0] = (i == 0) ? 8'h00 : 8'hff;
         t.rate[i*8+:8] = w[7:0];
         t.cks_en[i] = w[8];
         pl.push_back(w[7:0]);
         pl.push_back({7'h00, w[8]});
      end
      for (int i = 0; i < 8; i++) pl.push_back(8'(i % 2));
      pl.push_back(bd[15:8]);
      pl.push_back(bd[7:0]);
      t.baud = bd;
      t.baud_ok = bd inside {gbicp_pkg::BAUD_38400, gbicp_pkg::BAUD_19200,
         gbicp_pkg::BAUD_9600, gbicp_pkg::BAUD_4800, gbicp_pkg::BAUD_2400};
      if (bad == 0) e_nmea = t;
      if (bad == 0 && t.baud_ok) e_baud = bd;
      run(bad, 0, int'(bad == 0), 0, 0);
      chk("nmea cfg", 192'(e_nmea), 192'(nmea_cfg));
      chk("baud", 192'(e_baud), 192'(baud_out));
   endtask : do_nmea
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // Whole-run bound so a stuck parser still reaches the verdict.
   initial begin
      #9000000;
      errors++;
      complete_run();
   end
   // Main sequence: reset, initialize, refusals, switch, almanac.
   initial begin
      e_init = '0;
      e_nmea = '0;
      e_baud = gbicp_pkg::BAUD_4800;
      repeat (7) @(posedge core_clk);
      #1;
      chk("reset baud", 192'(e_baud), 192'(baud_out));
      chk("reset ready", 192'(0), 192'(rx_ready));
      @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      do_init(32'hffd700f9, 32'hffbe5266, 32'h003ac57a, 32'h000124f8,
              32'h0083d600, 16'h039c, 8'h0c, 8'h33, 0);
      jit = 1'b1;
      for (int i = 0; i < 9; i++) begin
         host.gap = i % 3;
         do_init(rnd(), rnd(), rnd(), rnd(), rnd(), 16'(rnd()),
                 8'(rnd() % 16), 8'(rnd() & 32'h7f), i < 6 ? 0 : i - 5);
      end
      for (int i = 0; i < 6; i++)
         do_nmea(i == 5 ? 16'h1234 : 16'(38400 >> i), 0);
      do_nmea(gbicp_pkg::BAUD_9600, 1);
      pl = {gbicp_pkg::ID_ALM};
      for (int k = 0; k < 448; k++) begin
         w = rnd();
         alm_e[k] = w[15:0];
         pl.push_back(w[15:8]);
         pl.push_back(w[7:0]);
      end
      run(0, 0, 0, 1, 0);
      jit = 1'b0;
      for (int k = 0; k < 8; k++) begin
         w = (k < 4) ? 32'(k * 149) : rnd() % 448;
         @(posedge core_clk);
         alm_rd_index <= w[8:0];
         repeat (2) @(posedge core_clk);
         #1;
         chk("almanac word", 192'(alm_e[w[8:0]]), 192'(alm_rd_data));
      end
      complete_run();
   end
endmodule : gbicp_parser_tb_top
`default_nettype wire
